// ### design/sbu_mux_pkg.sv
// Constants and carrier types for the sideband mux control block
package sbu_mux_pkg;
   localparam logic [6:0] primary_slave_address = 7'h5C;
   localparam logic [6:0] alternate_slave_address = 7'h5D;
   localparam logic [7:0] ptr_reset = 8'h00;
   localparam logic [7:0] off_revision = 8'h09;
   localparam logic [7:0] off_general_1 = 8'h0A;
   localparam logic [7:0] off_general_2 = 8'h0B;
   localparam int swap_bit_pos = 0;
   localparam int enable_bit_pos = 1;
   localparam logic [1:0] path_lane_b = 2'h0;
   localparam logic [1:0] path_audio = 2'h1;
   localparam logic [1:0] path_lane_c = 2'h2;
   localparam logic [1:0] path_lane_a = 2'h3;
   localparam logic [3:0] revision_default = 4'h0; // Arbitrary value
   localparam logic [7:0] reg_reset = 8'h00;
   localparam logic [3:0] bit_count_last = 4'h7;

   typedef enum logic [1:0] {
      strap_low = 2'h0,
      strap_mid = 2'h1,
      strap_high = 2'h2
   } strap_type;

   // One enable per switch contact
   typedef struct packed {
      logic a_to_lane_a_pos;
      logic a_to_lane_a_neg;
      logic b_to_lane_a_pos;
      logic b_to_lane_a_neg;
      logic a_to_lane_b_pos;
      logic a_to_lane_b_neg;
      logic b_to_lane_b_pos;
      logic b_to_lane_b_neg;
      logic a_to_lane_c_pos;
      logic b_to_lane_c_neg;
      logic a_to_audio_port_1;
      logic b_to_audio_port_2;
   } switch_type;

   typedef struct packed {
      logic orientation_swap_bit;
      logic enable_bit;
      logic [1:0] path_select_field;
   } config_type;
endpackage : sbu_mux_pkg

// ### design/sbu_route_decode.sv
// Path and orientation decoder for the sideband switch contacts
`timescale 1ns/1ps
module sbu_route_decode (
   input wire logic conduct,
   input wire logic [1:0] path,
   input wire logic swap,
   output sbu_mux_pkg::switch_type sw
);
   always_comb begin
      sw = '0;
      if (conduct) begin
         case (path)
            sbu_mux_pkg::path_lane_b: begin
               sw.a_to_lane_b_pos = !swap;
               sw.b_to_lane_b_neg = !swap;
               sw.a_to_lane_b_neg = swap;
               sw.b_to_lane_b_pos = swap;
            end
            sbu_mux_pkg::path_audio: begin
               sw.a_to_audio_port_1 = 1'b1;
               sw.b_to_audio_port_2 = 1'b1;
            end
            sbu_mux_pkg::path_lane_c: begin
               sw.a_to_lane_c_pos = 1'b1;
               sw.b_to_lane_c_neg = 1'b1;
            end
            default: begin
               sw.a_to_lane_a_pos = !swap;
               sw.b_to_lane_a_neg = !swap;
               sw.a_to_lane_a_neg = swap;
               sw.b_to_lane_a_pos = swap;
            end
         endcase
      end
   end
endmodule : sbu_route_decode

// ### design/sbu_mux_i2c_control.sv
// I2C slave, register file and switch control of the sideband mux
`timescale 1ns/1ps
module sbu_mux_i2c_control #(
   parameter bit four_way = 1'b0
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic switch_disable_pin,
   input wire sbu_mux_pkg::strap_type config_strap,
   input wire logic path_select_pin_hi,
   input wire logic path_select_pin_lo,
   input wire logic orientation_pin,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   output sbu_mux_pkg::switch_type switches,
   output logic shutdown,
   output logic in_reset
);
   typedef enum logic [5:0] {
      st_idle = 6'b000001,
      st_addr = 6'b000010,
      st_ack = 6'b000100,
      st_rx = 6'b001000,
      st_tx = 6'b010000,
      st_mack = 6'b100000
   } state_type;

   typedef struct packed {
      logic [1:0] scl_s;
      logic [1:0] sda_s;
      logic [1:0] dis_s;
      logic scl_d;
      logic sda_d;
      state_type st;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic rd;
      logic have_sub;
      logic [7:0] ptr;
      sbu_mux_pkg::config_type cfg;
      sbu_mux_pkg::strap_type strap;
      logic sda_o;
      logic ack_rd;
      logic [2:0] sel_s0;
      logic [2:0] sel_s1;
      sbu_mux_pkg::strap_type strap_s0;
      sbu_mux_pkg::strap_type strap_s1;
   } all_type;

   all_type cur_ff;
   all_type nxt_ff;
   logic scl_r, scl_f, start_c, stop_c, rst_h, i2c_mode, conduct;
   logic [6:0] my_addr;
   logic [7:0] rd_data;
   logic [1:0] path;
   logic swap;

   assign scl_r = cur_ff.scl_s[1] && !cur_ff.scl_d;
   assign scl_f = !cur_ff.scl_s[1] && cur_ff.scl_d;
   assign start_c = cur_ff.scl_s[1] && cur_ff.sda_d && !cur_ff.sda_s[1];
   assign stop_c = cur_ff.scl_s[1] && !cur_ff.sda_d && cur_ff.sda_s[1];
   assign rst_h = cur_ff.dis_s[1];
   assign i2c_mode = cur_ff.strap != sbu_mux_pkg::strap_low;
   assign my_addr = (cur_ff.strap == sbu_mux_pkg::strap_high) ?
      sbu_mux_pkg::alternate_slave_address :
      sbu_mux_pkg::primary_slave_address;

   always_comb begin
      case (cur_ff.ptr)
         sbu_mux_pkg::off_revision:
            rd_data = {4'h0, sbu_mux_pkg::revision_default};
         sbu_mux_pkg::off_general_1:
            rd_data = {6'h00, cur_ff.cfg.enable_bit,
               cur_ff.cfg.orientation_swap_bit};
         sbu_mux_pkg::off_general_2:
            rd_data = {6'h00, cur_ff.cfg.path_select_field};
         default: rd_data = 8'h00;
      endcase
   end

   always_comb begin
      nxt_ff = cur_ff;
      nxt_ff.scl_s = {cur_ff.scl_s[0], scl_in};
      nxt_ff.sda_s = {cur_ff.sda_s[0], sda_in};
      nxt_ff.dis_s = {cur_ff.dis_s[0], switch_disable_pin};
      nxt_ff.scl_d = cur_ff.scl_s[1];
      nxt_ff.sda_d = cur_ff.sda_s[1];
      // Select pins and strap are asynchronous: two stages each
      nxt_ff.sel_s0 = {path_select_pin_hi, path_select_pin_lo,
         orientation_pin};
      nxt_ff.sel_s1 = cur_ff.sel_s0;
      nxt_ff.strap_s0 = config_strap;
      nxt_ff.strap_s1 = cur_ff.strap_s0;
      if (rst_h) begin
         // Held in reset: interface silent, config and pointer cleared
         nxt_ff.st = st_idle;
         nxt_ff.sda_o = 1'b0;
         nxt_ff.ptr = sbu_mux_pkg::ptr_reset;
         nxt_ff.cfg = '0;
         nxt_ff.have_sub = 1'b0;
         nxt_ff.strap = cur_ff.strap_s1; // Strap caught while held in reset
      end else if (!i2c_mode) begin
         nxt_ff.st = st_idle;
         nxt_ff.sda_o = 1'b0;
      end else if (start_c) begin
         nxt_ff.st = st_addr;
         nxt_ff.cnt = 4'h0;
         nxt_ff.sda_o = 1'b0;
      end else if (stop_c) begin
         nxt_ff.st = st_idle;
         nxt_ff.sda_o = 1'b0;
      end else begin
         case (cur_ff.st)
            st_idle: nxt_ff.sda_o = 1'b0;
            st_addr, st_rx: begin
               if (scl_r) begin
                  nxt_ff.sh = {cur_ff.sh[6:0], cur_ff.sda_s[1]};
                  nxt_ff.cnt = cur_ff.cnt + 4'h1;
               end
               if (scl_f && cur_ff.cnt == 4'h8) begin
                  nxt_ff.cnt = 4'h0;
                  if (cur_ff.st == st_addr) begin
                     if (cur_ff.sh[7:1] == my_addr) begin
                        nxt_ff.rd = cur_ff.sh[0];
                        nxt_ff.have_sub = 1'b0;
                        nxt_ff.sda_o = 1'b1;
                        nxt_ff.st = st_ack;
                     end else begin
                        nxt_ff.st = st_idle;
                     end
                  end else begin
                     nxt_ff.sda_o = 1'b1;
                     nxt_ff.st = st_ack;
                     if (!cur_ff.have_sub) begin
                        nxt_ff.ptr = cur_ff.sh;
                        nxt_ff.have_sub = 1'b1;
                     end else begin
                        if (cur_ff.ptr == sbu_mux_pkg::off_general_1) begin
                           nxt_ff.cfg.enable_bit =
                              cur_ff.sh[sbu_mux_pkg::enable_bit_pos];
                           nxt_ff.cfg.orientation_swap_bit =
                              cur_ff.sh[sbu_mux_pkg::swap_bit_pos];
                        end
                        if (cur_ff.ptr == sbu_mux_pkg::off_general_2) begin
                           nxt_ff.cfg.path_select_field = cur_ff.sh[1:0];
                        end
                        nxt_ff.ptr = cur_ff.ptr + 8'h01;
                     end
                  end
               end
            end
            st_ack: begin
               if (scl_f) begin
                  if (cur_ff.rd) begin
                     nxt_ff.sh = rd_data;
                     nxt_ff.sda_o = !rd_data[7];
                     nxt_ff.cnt = 4'h1;
                     nxt_ff.st = st_tx;
                  end else begin
                     nxt_ff.sda_o = 1'b0;
                     nxt_ff.st = st_rx;
                  end
               end
            end
            st_tx: begin
               if (scl_f) begin
                  if (cur_ff.cnt == 4'h8) begin
                     nxt_ff.sda_o = 1'b0;
                     nxt_ff.ptr = cur_ff.ptr + 8'h01;
                     nxt_ff.st = st_mack;
                  end else begin
                     nxt_ff.sda_o = !cur_ff.sh[3'(bit_idx(cur_ff.cnt))];
                     nxt_ff.cnt = cur_ff.cnt + 4'h1;
                  end
               end
            end
            st_mack: begin
               if (scl_r) begin
                  nxt_ff.ack_rd = !cur_ff.sda_s[1];
               end
               if (scl_f) begin
                  if (cur_ff.ack_rd) begin
                     nxt_ff.sh = rd_data;
                     nxt_ff.sda_o = !rd_data[7];
                     nxt_ff.cnt = 4'h1;
                     nxt_ff.st = st_tx;
                  end else begin
                     nxt_ff.sda_o = 1'b0;
                     nxt_ff.st = st_idle;
                  end
               end
            end
            default: nxt_ff.st = st_idle;
         endcase
      end
   end

   function automatic logic [3:0] bit_idx(input logic [3:0] c);
      bit_idx = sbu_mux_pkg::bit_count_last - c;
   endfunction : bit_idx

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         cur_ff <= '0;
         cur_ff.scl_s <= 2'h3;
         cur_ff.sda_s <= 2'h3;
         cur_ff.dis_s <= 2'h3;
         cur_ff.scl_d <= 1'b1;
         cur_ff.sda_d <= 1'b1;
         cur_ff.st <= st_idle;
         cur_ff.ptr <= sbu_mux_pkg::ptr_reset;
         cur_ff.cfg <= '0;
         cur_ff.strap <= sbu_mux_pkg::strap_low;
      end else begin
         cur_ff <= nxt_ff;
      end
   end

   always_comb begin
      if (i2c_mode) begin
         path = cur_ff.cfg.path_select_field;
         swap = cur_ff.cfg.orientation_swap_bit;
      end else begin
         path = cur_ff.sel_s1[2:1];
         swap = four_way ? 1'b0 : cur_ff.sel_s1[0];
      end
   end

   // SDA pull drops in the same cycle that reset is seen
   assign conduct = !rst_h && (!i2c_mode || cur_ff.cfg.enable_bit);
   assign shutdown = !rst_h && i2c_mode && !cur_ff.cfg.enable_bit;
   assign in_reset = rst_h;
   assign sda_out = 1'b0;
   assign sda_oe = cur_ff.sda_o && !rst_h;

   sbu_route_decode u_decode (
      .conduct(conduct),
      .path(path),
      .swap(swap),
      .sw(switches)
   );
endmodule : sbu_mux_i2c_control

// ### tb/sbu_mux_i2c_control_asserts.sv
// Port-level checks of the sideband mux control block
`timescale 1ns/1ps
module sbu_mux_i2c_control_asserts #(
   parameter bit four_way = 1'b0
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic switch_disable_pin,
   input wire sbu_mux_pkg::strap_type config_strap,
   input wire logic path_select_pin_hi,
   input wire logic path_select_pin_lo,
   input wire logic orientation_pin,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire sbu_mux_pkg::switch_type switches,
   input wire logic shutdown,
   input wire logic in_reset
);
   localparam logic [11:0] tab [8] = '{12'h090, 12'h060, 12'h003,
      12'h003, 12'h00C, 12'h00C, 12'h900, 12'h600};
   logic pin_mode;
   logic [2:0] sel;
   assign pin_mode = !in_reset && config_strap == sbu_mux_pkg::strap_low;
   assign sel = {path_select_pin_hi, path_select_pin_lo,
                 orientation_pin & !four_way};
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   property p_drain; !sda_out; endproperty
   a_drain: assert property (p_drain) else $error("sda_out high");
   property p_rst_open; in_reset |-> switches == 12'h000; endproperty
   a_rst_open: assert property (p_rst_open) else $error("closed");
   property p_shut; shutdown |-> switches == 12'h000 && !in_reset; endproperty
   a_shut: assert property (p_shut) else $error("shutdown");
   property p_quiet; in_reset || pin_mode |-> !sda_oe; endproperty
   a_quiet: assert property (p_quiet) else $error("sda driven");
   property p_sync; switch_disable_pin [*3] |=> in_reset; endproperty
   a_sync: assert property (p_sync) else $error("no reset");
   property p_run; !switch_disable_pin [*3] |=> !in_reset; endproperty
   a_run: assert property (p_run) else $error("stuck reset");
   // Select pins reach the contacts through two synchroniser stages
   property p_pin; pin_mode |-> switches == tab[$past(sel, 2)]; endproperty
   a_pin: assert property (p_pin) else $error("pin route");
   property p_pin_on; pin_mode |-> !shutdown; endproperty
   a_pin_on: assert property (p_pin_on) else $error("pin shutdown");
   property p_pair; switches == 12'h000 || $countones(switches) == 2;
   endproperty
   a_pair: assert property (p_pair) else $error("contacts");
   c_shut: cover property (shutdown);
   c_ack: cover property ($rose(sda_oe));
   c_flip: cover property (pin_mode && switches == 12'h600);
endmodule : sbu_mux_i2c_control_asserts

// ### tb/sbu_i2c_master.sv
// Behavioural I2C master for the block's bus lines
`timescale 1ns/1ps
module sbu_i2c_master (
   input wire logic sys_clk,
   input wire logic sda,
   output logic scl,
   output logic sda_low
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic bit_xfer(input logic b, output logic r);
      @(posedge sys_clk);
      sda_low <= !b;
      repeat (3) @(posedge sys_clk);
      scl <= 1'b1;
      repeat (2) @(posedge sys_clk);
      r = sda;
      repeat (2) @(posedge sys_clk);
      scl <= 1'b0;
   endtask : bit_xfer
   task automatic start();
      sda_low <= 1'b1;
      repeat (4) @(posedge sys_clk);
      scl <= 1'b0;
   endtask : start
   task automatic stop();
      @(posedge sys_clk);
      sda_low <= 1'b1;
      repeat (3) @(posedge sys_clk);
      scl <= 1'b1;
      repeat (4) @(posedge sys_clk);
      sda_low <= 1'b0;
      repeat (4) @(posedge sys_clk);
   endtask : stop
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_xfer(d[i], r);
      bit_xfer(1'b1, r);
      ack = !r;
   endtask : wbyte
   task automatic rbyte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_xfer(1'b1, d[i]);
      bit_xfer(last, r);
   endtask : rbyte
endmodule : sbu_i2c_master

// ### tb/testbench.sv
// Self-checking bench for the sideband mux control block
`timescale 1ns/1ps
module testbench;
   localparam logic [11:0] tab [8] = '{12'h090, 12'h060, 12'h003,
      12'h003, 12'h00C, 12'h00C, 12'h900, 12'h600};
   localparam logic [6:0] pa = sbu_mux_pkg::primary_slave_address;
   localparam logic [6:0] aa = sbu_mux_pkg::alternate_slave_address;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic dis = 1'b1;
   sbu_mux_pkg::strap_type strap = sbu_mux_pkg::strap_low;
   logic [2:0] pins = 3'h0;
   logic scl, m_low, sda_oe, sda_out, shutdown, in_reset, ack;
   logic [7:0] rd;
   sbu_mux_pkg::switch_type sw;
   wire sda = !(m_low || sda_oe);
   int err_count = 0;
   int comparisons = 0;
   int cycles = 0;
   always #50 sys_clk = !sys_clk;
   sbu_mux_i2c_control dut (.sys_clk(sys_clk), .nrst(nrst),
      .switch_disable_pin(dis), .config_strap(strap),
      .path_select_pin_hi(pins[2]), .path_select_pin_lo(pins[1]),
      .orientation_pin(pins[0]), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe), .switches(sw),
      .shutdown(shutdown), .in_reset(in_reset));
   sbu_i2c_master master (.sys_clk(sys_clk), .sda(sda), .scl(scl),
      .sda_low(m_low));
   task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic results();
      if (err_count == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : results
   task automatic setmode(input sbu_mux_pkg::strap_type s);
      dis <= 1'b1;
      repeat (4) @(posedge sys_clk);
      strap <= s;
      repeat (4) @(posedge sys_clk);
      dis <= 1'b0;
      repeat (6) @(posedge sys_clk);
   endtask : setmode
   task automatic wr(input logic [6:0] a, input logic x, input logic [7:0] s,
                     input int n, input logic [7:0] d0, input logic [7:0] d1);
      master.start();
      master.wbyte({a, 1'b0}, ack);
      chk(12'(ack), 12'(x));
      if (x) begin
         master.wbyte(s, ack);
         chk(12'(ack), 12'h001);
         if (n > 0) master.wbyte(d0, ack);
         if (n > 1) master.wbyte(d1, ack);
         chk(12'(ack), 12'h001);
      end
      master.stop();
      repeat (2) @(posedge sys_clk);
   endtask : wr
   task automatic rdn(input logic [7:0] e [3], input int n);
      master.start();
      master.wbyte({pa, 1'b1}, ack);
      chk(12'(ack), 12'h001);
      for (int i = 0; i < n; i++) begin
         master.rbyte(i == n - 1, rd);
         chk(12'(rd), 12'(e[i]));
      end
      master.stop();
   endtask : rdn
   task automatic t_pin();
      for (int i = 0; i < 8; i++) begin
         pins <= 3'(i);
         repeat (3) @(posedge sys_clk);
         chk(sw, tab[i]);
         chk(12'(shutdown), 12'h000);
      end
      dis <= 1'b1;
      repeat (4) @(posedge sys_clk);
      chk(sw, 12'h000);
   endtask : t_pin
   task automatic t_reg();
      setmode(sbu_mux_pkg::strap_mid);
      chk({sw[11:1], shutdown}, 12'h001);
      for (int i = 0; i < 8; i++) begin
         wr(pa, 1'b1, 8'h0A, 2, {7'h01, i[0]}, {6'h00, i[2:1]});
         chk(sw, tab[i]);
      end
      pins <= 3'h0;
      repeat (3) @(posedge sys_clk);
      chk(sw, 12'h600);
   endtask : t_reg
   task automatic t_rd();
      wr(pa, 1'b1, 8'h09, 0, 8'h00, 8'h00);
      rdn('{8'h00, 8'h03, 8'h03}, 3);
      wr(pa, 1'b1, 8'h0B, 0, 8'h00, 8'h00);
      rdn('{8'h03, 8'h00, 8'h00}, 1);
      rdn('{8'h00, 8'h00, 8'h00}, 1);
   endtask : t_rd
   task automatic t_shut();
      wr(pa, 1'b1, 8'h0A, 1, 8'h00, 8'h00);
      chk({sw[11:1], shutdown}, 12'h001);
      rdn('{8'h03, 8'h00, 8'h00}, 1);
   endtask : t_shut
   task automatic t_addr();
      wr(aa, 1'b0, 8'h00, 0, 8'h00, 8'h00);
      setmode(sbu_mux_pkg::strap_high);
      wr(aa, 1'b1, 8'h0A, 1, 8'h03, 8'h00);
      chk(sw, 12'h060);
      wr(pa, 1'b0, 8'h00, 0, 8'h00, 8'h00);
      dis <= 1'b1;
      repeat (4) @(posedge sys_clk);
      wr(aa, 1'b0, 8'h00, 0, 8'h00, 8'h00);
      chk({sw[11:1], in_reset}, 12'h001);
   endtask : t_addr
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         results();
      end
   end
   initial begin
      repeat (3) @(posedge sys_clk);
      nrst <= 1'b1;
      setmode(sbu_mux_pkg::strap_low);
      t_pin();
      t_reg();
      t_rd();
      t_shut();
      t_addr();
      results();
   end
endmodule : testbench
bind sbu_mux_i2c_control sbu_mux_i2c_control_asserts #(.four_way(four_way))
   chk_i (.sys_clk(sys_clk), .nrst(nrst),
   .switch_disable_pin(switch_disable_pin), .config_strap(config_strap),
   .path_select_pin_hi(path_select_pin_hi),
   .path_select_pin_lo(path_select_pin_lo),
   .orientation_pin(orientation_pin), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe(sda_oe), .switches(switches),
   .shutdown(shutdown), .in_reset(in_reset));
